// file: bench/spm_port_assertions.sv
// Concurrent checks on the serial port top-level ports.
// Assumes a bind from the bench top; single clock domain.
`timescale 1ns/1ps
`default_nettype none
module spm_port_assertions (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Watched ports
  input wire logic ctrl_wr_i,
  input wire spm_pkg::spm_byte_t ctrl_o,
  input wire logic data_wr_i,
  input wire logic data_rd_i,
  input wire logic done_flag_o,
  input wire logic mode_fault_o,
  input wire logic tx_empty_o,
  input wire logic busy_o,
  input wire logic rx_valid_o,
  input wire logic ss_n_i,
  input wire logic sck_o,
  input wire logic miso_oe_o
);
  import spm_pkg::*;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);
  logic en_m;
  logic no_rate;
  assign en_m = ctrl_o[6] && ctrl_o[4];
  assign no_rate = ({ctrl_o[7], ctrl_o[1:0]} == 3'h0) || ({ctrl_o[7], ctrl_o[1:0]} == 3'h7);
  ////////////////////////////////////////
  // Six cycles covers the pin synchroniser
  AST_DESEL_RELEASE: assert property (
    (ss_n_i && !(ctrl_o[5] && ctrl_o[2]))[*6] |-> !miso_oe_o) else $error("miso driven");
  AST_SELECT_PIN_DISABLE_BIT_NO_FAULT: assert property (
    en_m && ctrl_o[5] |=> !$rose(mode_fault_o)) else $error("fault with select disabled");
  AST_FAULT_DROPS_EN: assert property (
    $rose(mode_fault_o) |-> !ctrl_o[6] && !ctrl_o[4]) else $error("fault kept enable");
  AST_NO_RATE_STILL: assert property (
    en_m && no_rate && !ctrl_wr_i && $stable(ctrl_o) |=> $stable(sck_o))
    else $error("clock runs on unused rate");
  AST_IDLE_LEVEL: assert property (
    en_m && !busy_o && $stable(ctrl_o) |-> sck_o == ctrl_o[3]) else $error("idle level");
  AST_DONE_WITH_DATA: assert property (
    $rose(done_flag_o) |-> rx_valid_o) else $error("done without data");
  AST_DONE_CLEAR: assert property (
    $fell(done_flag_o) |-> $past(data_rd_i)) else $error("done cleared early");
  AST_TX_TAKEN: assert property (
    data_wr_i && tx_empty_o && ctrl_o[6] && !ctrl_wr_i |=> !tx_empty_o)
    else $error("empty flag stuck");
  AST_FAULT_KEPT: assert property (
    $fell(mode_fault_o) |-> $past(ctrl_wr_i)) else $error("fault cleared early");
  cover property ($rose(done_flag_o));
  cover property ($rose(mode_fault_o));
  cover property (busy_o && data_wr_i && tx_empty_o);
endmodule : spm_port_assertions
`default_nettype wire

// file: bench/spm_port_tb.sv
// Bench for the serial port: rates, queueing, flags, fault, slave.
// Assumes the slave model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module spm_port_tb;
  import spm_pkg::*;
  logic sys_clk_i, reset_i, ctrl_wr_i, status_rd_i, data_wr_i, data_rd_i;
  logic ss_n, rsck, rmosi, mss_n, mmiso, sck_w, mosi_w, miso_w;
  spm_byte_t ctrl_byte_i, data_wr_byte_i, ctrl_o, rx_data_o, stx, srx, q;
  logic done_flag_o, mode_fault_o, overrun_o, tx_empty_o, busy_o, rx_valid_o;
  logic sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
  logic [7:0] fl;
  int bad_count, num_checks, cyc, nsck, nfall, hp;
  realtime tprev, tlast;
  assign sck_w = sck_oe_o ? sck_o : rsck;
  assign mosi_w = mosi_oe_o ? mosi_o : rmosi;
  assign miso_w = miso_oe_o ? miso_o : mmiso;
  assign fl = {done_flag_o, mode_fault_o, overrun_o, tx_empty_o, busy_o, rx_valid_o,
    miso_oe_o, sck_o};
  spm_port #(.RX_DEPTH(2)) dut_u (.sys_clk_i, .reset_i, .ctrl_wr_i, .ctrl_byte_i,
    .ctrl_o, .status_rd_i, .done_flag_o, .mode_fault_o, .overrun_o, .tx_empty_o, .busy_o,
    .data_wr_i, .data_wr_byte_i, .data_rd_i, .rx_valid_o, .rx_data_o, .ss_n_i(ss_n),
    .sck_i(sck_w), .sck_o, .sck_oe_o, .mosi_i(mosi_w), .mosi_o, .mosi_oe_o,
    .miso_i(miso_w), .miso_o, .miso_oe_o);
  spm_slave_model sl_u (.ss_n_i(mss_n), .sck_i(sck_w), .mosi_i(mosi_w), .miso_o(mmiso),
    .tx_i(stx), .rx_o(srx));
  ////////////////////////////////////////
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sck_o) nsck++;
  always @(negedge busy_o) nfall++;
  always @(sck_o) begin
    tprev = tlast;
    tlast = $realtime;
  end
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic chk(input string n, input logic [7:0] m, input logic [7:0] e,
    input logic [7:0] g);
    num_checks++;
    if ((g & m) !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", n, e, g & m);
    end
  endtask : chk
  // One strobe per call; kinds: 0 control, 1 data write, 2 data read, 3 status
  task automatic op(input int k, input spm_byte_t b);
    @(posedge sys_clk_i);
    ctrl_wr_i <= (k == 0);
    data_wr_i <= (k == 1);
    data_rd_i <= (k == 2);
    status_rd_i <= (k == 3);
    ctrl_byte_i <= b;
    data_wr_byte_i <= b;
    @(posedge sys_clk_i);
    {ctrl_wr_i, data_wr_i, data_rd_i, status_rd_i} <= 4'h0;
    #1;
  endtask : op
  task automatic rx(input spm_byte_t e);
    chk("rx_data", 8'hFF, e, rx_data_o);
    op(2, 8'h00);
  endtask : rx
  task automatic idle();
    repeat (4) @(posedge sys_clk_i);
    while (busy_o !== 1'b0) @(posedge sys_clk_i);
    // Master receive lands a few cycles after the last clock edge
    repeat (6) @(posedge sys_clk_i);
    #1;
  endtask : idle
  task automatic sel(input spm_byte_t s);
    @(posedge sys_clk_i);
    mss_n <= 1'b1;
    stx <= s;
    @(posedge sys_clk_i);
    mss_n <= 1'b0;
  endtask : sel
  task automatic sx(input spm_byte_t m, input spm_byte_t s);
    sel(s);
    op(1, m);
    idle();
    chk("slave_rx", 8'hFF, m, srx);
  endtask : sx
  // Remote master at 125 ns per bit, mode 0
  task automatic rm(input spm_byte_t b);
    ss_n = 1'b0;
    #200;
    chk("miso_oe", 8'h02, 8'h02, fl);
    for (int i = 7; i >= 0; i--) begin
      rmosi = b[i];
      #62.5;
      rsck = 1'b1;
      q[i] = miso_w;
      #62.5;
      rsck = 1'b0;
    end
    #200;
    ss_n = 1'b1;
    #200;
  endtask : rm
  task automatic tend(input string n);
    $display("test %s done", n);
  endtask : tend
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  ////////////////////////////////////////
  initial begin
    {reset_i, ss_n, mss_n} = 3'h7;
    {ctrl_wr_i, status_rd_i, data_wr_i, data_rd_i, rsck, rmosi} = 6'h00;
    {ctrl_byte_i, data_wr_byte_i, stx} = 24'h000000;
    repeat (6) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    #1;
    chk("ctrl", 8'hFF, 8'h00, ctrl_o);
    chk("flags", 8'hFF, 8'h10, fl);
    tend("reset");
    for (int c = 1; c <= 6; c++) begin
      op(0, {c[2], 7'h70} | {6'h00, c[1:0]});
      nsck = 0;
      sx(8'hA0 + 8'(c), 8'h3C ^ 8'(c));
      rx(8'h3C ^ 8'(c));
      hp = int'((tlast - tprev) / 10.0);
      chk("sck_cycles", 8'hFF, 8'h08, nsck[7:0]);
      chk("half_period", 8'hFF, 8'h01 << c, hp[7:0]);
    end
    tend("rates");
    op(0, 8'h71);
    for (int i = 1; i <= 3; i++) sx(8'(i), 8'h50 + 8'(i));
    chk("flags", 8'hE4, 8'hA4, fl);
    rx(8'h51);
    chk("flags", 8'h80, 8'h80, fl);
    op(3, 8'h00);
    rx(8'h52);
    chk("flags", 8'hE4, 8'h00, fl);
    tend("overrun");
    sel(8'h77);
    nfall = 0;
    nsck = 0;
    op(1, 8'h12);
    op(1, 8'h34);
    chk("flags", 8'h18, 8'h08, fl);
    idle();
    chk("busy_falls", 8'hFF, 8'h01, nfall[7:0]);
    chk("sck_cycles", 8'hFF, 8'h10, nsck[7:0]);
    chk("slave_rx", 8'hFF, 8'h34, srx);
    rx(8'h77);
    rx(8'h77);
    tend("queue");
    @(posedge sys_clk_i);
    ss_n <= 1'b0;
    op(0, 8'h71);
    repeat (8) @(posedge sys_clk_i);
    chk("flags", 8'h40, 8'h00, fl);
    op(0, 8'h51);
    repeat (8) @(posedge sys_clk_i);
    chk("ctrl", 8'hFF, 8'h01, ctrl_o);
    op(0, 8'h00);
    chk("flags", 8'h40, 8'h40, fl);
    op(3, 8'h00);
    op(0, 8'h00);
    chk("flags", 8'h40, 8'h00, fl);
    ss_n <= 1'b1;
    tend("fault");
    op(0, 8'h78);
    chk("flags", 8'h01, 8'h01, fl);
    op(1, 8'hF0);
    repeat (20) @(posedge sys_clk_i);
    chk("flags", 8'h09, 8'h09, fl);
    op(0, 8'h00);
    idle();
    chk("flags", 8'h18, 8'h10, fl);
    tend("stall");
    op(0, 8'h40);
    op(1, 8'h96);
    rm(8'h2B);
    chk("miso_byte", 8'hFF, 8'h96, q);
    chk("flags", 8'h82, 8'h80, fl);
    rx(8'h2B);
    rm(8'h11);
    chk("miso_byte", 8'hFF, 8'h2B, q);
    rx(8'h11);
    tend("slave");
    test_done();
  end
endmodule : spm_port_tb
bind spm_port spm_port_assertions chk_u (.sys_clk_i, .reset_i, .ctrl_wr_i, .ctrl_o,
  .data_wr_i, .data_rd_i, .done_flag_o, .mode_fault_o, .tx_empty_o, .busy_o, .rx_valid_o,
  .ss_n_i, .sck_o, .miso_oe_o);
`default_nettype wire

// file: bench/spm_slave_model.sv
// Behavioural remote slave, clock mode 0, for master-mode runs.
// Assumes the bench drives its select and the byte to return.
`timescale 1ns/1ps
`default_nettype none
module spm_slave_model (
  // Link
  input wire logic ss_n_i,
  input wire logic sck_i,
  input wire logic mosi_i,
  output logic miso_o,
  // Bench side
  input wire spm_pkg::spm_byte_t tx_i,
  output spm_pkg::spm_byte_t rx_o
);
  import spm_pkg::*;
  spm_byte_t sh_r;
  initial begin
    sh_r = 8'h00;
    rx_o = 8'h00;
  end
  // First bit ready before the first edge
  always @(negedge ss_n_i) sh_r = tx_i;
  always @(posedge sck_i) if (!ss_n_i) rx_o = {rx_o[6:0], mosi_i};
  // Rotation repeats the byte while select stays low
  always @(negedge sck_i) if (!ss_n_i) sh_r = {sh_r[6:0], sh_r[7]};
  // Released line shows the inverse, never a stale bit
  assign miso_o = ss_n_i ? ~sh_r[7] : sh_r[7];
endmodule : spm_slave_model
`default_nettype wire

// file: rtl/spm_cfg.svh
// Bit positions, reset values and counts for the serial port.
// Assumes inclusion by bare name from the port module.
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH

// Control byte layout
`define SPM_CTL_RATE_HI 7
`define SPM_CTL_EN 6
`define SPM_CTL_SELECT_PIN_DISABLE_BIT 5
`define SPM_CTL_MASTER 4
`define SPM_CTL_CPOL 3
`define SPM_CTL_CPHA 2
`define SPM_CTL_RATE_MID 1
`define SPM_CTL_RATE_LO 0

// Reset values
`define SPM_CTL_RST 8'h00
`define SPM_DATA_RST 8'h00
`define SPM_PIN_RST 4'h8

// Sixteen clock edges make the eight clock cycles of one byte
`define SPM_EDGE_FIRST 4'h0
`define SPM_EDGE_LAST 4'hF

// Rate codes without a baud generator
`define SPM_RATE_NONE_LO 3'h0
`define SPM_RATE_NONE_HI 3'h7

`endif

// file: rtl/spm_fifo2.sv
// Small valid/ready buffer for received bytes.
// Assumes one clock domain; DEPTH a power of two.
`timescale 1ns/1ps
`default_nettype none

module spm_fifo2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
      $error("spm_fifo2: DEPTH must be a power of two, at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // Count is one bit wider than the pointers so that full is not read as empty
  assign in_ready_o = (count_r != (AW + 1)'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign out_data_o = mem_r[rd_ptr_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule : spm_fifo2

`default_nettype wire

// file: rtl/spm_pkg.sv
// Types shared by the serial port modules.
// Assumes the configuration header is on the include path.
package spm_pkg;

  typedef logic [7:0] spm_byte_t;
  typedef logic [2:0] spm_rate_t;

  typedef enum logic [1:0] {
    SPM_IDLE = 2'b01,
    SPM_XFER = 2'b10
  } spm_state_t;

endpackage : spm_pkg

// file: rtl/spm_port.sv
// Serial port, master or slave, one byte per eight clock cycles.
// Assumes pins are asynchronous; control and data strobes are local.
//
// Contract
// R01 - Bytes are eight bits, most significant bit first on both lines.
// R02 - Master gives eight clock cycles per byte; slave shifts only on them.
// R03 - Deselected slave releases its output line.
// R04 - Master with select disabled: select pin is free, no mode fault.
// R05 - Slave with phase and select disable set is always selected.
// R06 - Clearing select disable leaves the mode fault flag alone.
// R07 - Rate codes 1 to 6 divide by 4 to 128; 0 and 7 no clock.
// R08 - Remote master keeps its clock at most a quarter of ours.
// R09 - Every transfer shifts one byte out and one byte in together.
// R10 - Master data write starts a transfer through the shift register.
// R11 - Master completion sets done flag and stores the received byte.
// R12 - Done flag clears after status read while set, then data read.
// R13 - Remote master holds select low for the whole slave transfer.
// R14 - Slave completion stores the received byte and sets done flag.
// R15 - Slave write too late resends what the shift register holds.
// R16 - Phase clear: first edge samples, select falling starts each byte.
// R17 - Phase set: first edge starts; select may stay low between bytes.
// R18 - Polarity sets idle clock level; phase picks sample and shift edges.
// R19 - A queued byte follows the current one with no gap.
// R20 - Buffer empty flag set while a byte can be accepted.
// R21 - Slave without a new byte sends the last byte received.
// R22 - Software disables before changing format and picks role first.
// R23 - Master mode fault sets fault flag, clears enable and master.
// R24 - Overrun drops the new byte and keeps the unread ones.
// R25 - Clearing enable stops and resets the port logic.
// R26 - After reset: disabled, flags clear, buffer empty, idle.
`timescale 1ns/1ps
`default_nettype none

`include "spm_cfg.svh"

module spm_port #(
  parameter int RX_DEPTH = 2
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Control byte
  input wire logic ctrl_wr_i,
  input wire spm_pkg::spm_byte_t ctrl_byte_i,
  output spm_pkg::spm_byte_t ctrl_o,
  // Status
  input wire logic status_rd_i,
  output logic done_flag_o,
  output logic mode_fault_o,
  output logic overrun_o,
  output logic tx_empty_o,
  output logic busy_o,
  // Transmit data
  input wire logic data_wr_i,
  input wire spm_pkg::spm_byte_t data_wr_byte_i,
  // Receive data
  input wire logic data_rd_i,
  output logic rx_valid_o,
  output spm_pkg::spm_byte_t rx_data_o,
  // Serial pins
  input wire logic ss_n_i,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_o,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_o
);

  import spm_pkg::*;

  //////////////////////////////////////////////////
  // Declarations

  spm_byte_t ctrl_r;
  spm_byte_t sh_r;
  spm_byte_t hold_r;
  spm_byte_t rx_byte;
  spm_state_t state_r;
  spm_rate_t rate;
  logic [3:0] edge_r;
  logic [7:0] div_r;
  logic [7:0] half_m1;
  logic samp_r;
  logic tog_r;
  logic full_r;
  logic go_r;
  logic sck_d_r;
  logic sel_d_r;
  logic done_r;
  logic done_arm_r;
  logic fault_r;
  logic fault_arm_r;
  logic ovr_r;
  logic ovr_arm_r;
  logic en;
  logic master;
  logic select_pin_disable_bit;
  logic cpha;
  logic cpol;
  logic ss_s;
  logic sck_s;
  logic mosi_s;
  logic miso_s;
  logic din;
  logic sel;
  logic rate_ok;
  logic tick;
  logic slave_edge;
  logic edge_ev;
  logic sample_edge;
  logic complete;
  logic load_idle;
  logic load_now;
  logic drop;
  logic fault_ev;
  logic rx_ready;
  logic [3:0] mpipe_r;
  logic [3:0] mlast_r;
  spm_byte_t mrx_r;
  spm_byte_t rx_word;
  logic m_done;
  logic rx_push;

  //////////////////////////////////////////////////
  // Control decode

  assign en = ctrl_r[`SPM_CTL_EN];
  assign master = ctrl_r[`SPM_CTL_MASTER];
  assign select_pin_disable_bit = ctrl_r[`SPM_CTL_SELECT_PIN_DISABLE_BIT];
  assign cpha = ctrl_r[`SPM_CTL_CPHA];
  assign cpol = ctrl_r[`SPM_CTL_CPOL];
  assign rate = {ctrl_r[`SPM_CTL_RATE_HI], ctrl_r[`SPM_CTL_RATE_MID],
                 ctrl_r[`SPM_CTL_RATE_LO]};

  // Fault wins over a write landing in the same cycle
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_r <= `SPM_CTL_RST; // R26
    end else if (fault_ev) begin
      ctrl_r[`SPM_CTL_EN] <= 1'b0; // R23
      ctrl_r[`SPM_CTL_MASTER] <= 1'b0; // R23
    end else if (ctrl_wr_i) begin
      ctrl_r <= ctrl_byte_i;
    end
  end

  //////////////////////////////////////////////////
  // Pin synchronisers

  spm_sync #(
    .WIDTH(4),
    .RST_VAL(`SPM_PIN_RST)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .async_i({ss_n_i, sck_i, mosi_i, miso_i}),
    .sync_o({ss_s, sck_s, mosi_s, miso_s})
  );

  // Forced select only with phase set; without it the pin still frames
  assign sel = (select_pin_disable_bit && cpha) ? 1'b1 : !ss_s; // R05
  assign din = master ? miso_s : mosi_s; // R09

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sck_d_r <= 1'b0;
      sel_d_r <= 1'b0;
    end else begin
      sck_d_r <= sck_s;
      sel_d_r <= sel;
    end
  end

  //////////////////////////////////////////////////
  // Baud generator

  assign rate_ok = (rate != `SPM_RATE_NONE_LO) && (rate != `SPM_RATE_NONE_HI); // R07
  // Half period is 2 to the rate code, so the full divide is 4 to 128
  assign half_m1 = (8'h01 << rate) - 8'h01; // R07
  assign tick = en && master && rate_ok && (state_r == SPM_XFER) && (div_r == half_m1);

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      div_r <= 8'h00;
    end else if (!en || !master || (state_r != SPM_XFER) || tick) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  //////////////////////////////////////////////////
  // Edge events

  // Slave counts only edges of the remote clock while selected
  assign slave_edge = en && !master && sel && (sck_s != sck_d_r)
                      && (cpha || go_r || (state_r == SPM_XFER)); // R02 R16 R17
  assign edge_ev = master ? tick : slave_edge; // R02
  assign sample_edge = (edge_r[0] == cpha); // R18
  assign complete = edge_ev && (edge_r == `SPM_EDGE_LAST); // R02
  assign rx_byte = {sh_r[6:0], cpha ? din : samp_r}; // R01
  assign drop = !master && !sel; // R03
  assign load_idle = en && full_r && (state_r == SPM_IDLE) && !edge_ev && !drop;
  assign load_now = load_idle || (complete && full_r); // R19

  // Phase clear slave: each byte needs a fresh falling select
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      go_r <= 1'b0;
    end else if (!en || drop || complete) begin
      go_r <= 1'b0; // R16
    end else if (sel && !sel_d_r) begin
      go_r <= 1'b1; // R16
    end
  end

  //////////////////////////////////////////////////
  // Transfer engine

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= SPM_IDLE; // R26
      edge_r <= `SPM_EDGE_FIRST;
      tog_r <= 1'b0;
      samp_r <= 1'b0;
      sh_r <= `SPM_DATA_RST;
    end else if (!en || drop) begin
      // Disable or deselect clears the byte counter, shifter kept
      state_r <= SPM_IDLE; // R25 R03
      edge_r <= `SPM_EDGE_FIRST;
      tog_r <= 1'b0;
    end else begin
      if (load_idle) begin
        sh_r <= hold_r; // R10 R15
        if (master) begin
          state_r <= SPM_XFER; // R10
        end
      end
      if (edge_ev) begin
        edge_r <= edge_r + 4'h1;
        tog_r <= !tog_r; // R18
        if (state_r == SPM_IDLE) begin
          state_r <= SPM_XFER;
        end
        if (sample_edge) begin
          samp_r <= din; // R18
        end
        if (complete) begin
          if (full_r) begin
            sh_r <= hold_r; // R19
          end else begin
            sh_r <= rx_byte; // R21
            state_r <= SPM_IDLE;
          end
        end else if (!sample_edge && (edge_r != `SPM_EDGE_FIRST)) begin
          sh_r <= {sh_r[6:0], samp_r}; // R01 R09
        end
      end
    end
  end

  //////////////////////////////////////////////////
  // Master receive, delayed past the pin synchroniser

  // The returned bit reaches us four cycles after our own clock edge,
  // so each sample is taken four cycles late; this keeps the divide by 4
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mpipe_r <= 4'h0;
      mlast_r <= 4'h0;
      mrx_r <= `SPM_DATA_RST;
    end else if (!en || !master) begin
      mpipe_r <= 4'h0;
      mlast_r <= 4'h0;
    end else begin
      mpipe_r <= {mpipe_r[2:0], edge_ev && sample_edge}; // R09
      mlast_r <= {mlast_r[2:0], edge_ev && sample_edge && (edge_r[3:1] == 3'h7)};
      if (mpipe_r[3]) begin
        mrx_r <= {mrx_r[6:0], miso_s}; // R01
      end
    end
  end

  assign m_done = mpipe_r[3] && mlast_r[3]; // R11
  assign rx_push = master ? m_done : complete; // R11 R14
  assign rx_word = master ? {mrx_r[6:0], miso_s} : rx_byte; // R01

  //////////////////////////////////////////////////
  // Transmit holding byte

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      full_r <= 1'b0; // R26
      hold_r <= `SPM_DATA_RST;
    end else if (!en) begin
      full_r <= 1'b0; // R25
    end else if (load_now) begin
      full_r <= 1'b0; // R20
    end else if (data_wr_i && !full_r) begin
      // Writes while full are dropped; software watches the empty flag
      full_r <= 1'b1; // R20
      hold_r <= data_wr_byte_i;
    end
  end

  //////////////////////////////////////////////////
  // Receive buffer

  spm_fifo2 #(
    .WIDTH(8),
    .DEPTH(RX_DEPTH)
  ) u_rx (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .in_valid_i(rx_push),
    .in_ready_o(rx_ready),
    .in_data_i(rx_word),
    .out_valid_o(rx_valid_o),
    .out_ready_i(data_rd_i),
    .out_data_o(rx_data_o)
  ); // R11 R14 R24

  //////////////////////////////////////////////////
  // Status flags, hardware set wins over clear

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      done_r <= 1'b0; // R26
      done_arm_r <= 1'b0;
    end else if (rx_push) begin
      done_r <= 1'b1; // R11 R14
      done_arm_r <= 1'b0;
    end else if (done_arm_r && data_rd_i) begin
      done_r <= 1'b0; // R12
      done_arm_r <= 1'b0;
    end else if (status_rd_i && done_r) begin
      done_arm_r <= 1'b1; // R12
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ovr_r <= 1'b0;
      ovr_arm_r <= 1'b0;
    end else if (rx_push && !rx_ready) begin
      ovr_r <= 1'b1; // R24
      ovr_arm_r <= 1'b0;
    end else if (ovr_arm_r && data_rd_i) begin
      ovr_r <= 1'b0;
      ovr_arm_r <= 1'b0;
    end else if (status_rd_i && ovr_r) begin
      ovr_arm_r <= 1'b1;
    end
  end

  // Select low on an enabled master means a second master is driving
  assign fault_ev = en && master && !select_pin_disable_bit && !ss_s; // R04 R23

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fault_r <= 1'b0; // R26
      fault_arm_r <= 1'b0;
    end else if (fault_ev) begin
      fault_r <= 1'b1; // R23
      fault_arm_r <= 1'b0;
    end else if (fault_arm_r && ctrl_wr_i) begin
      // Only the read-then-write pair clears it, never a bit value
      fault_r <= 1'b0; // R06
      fault_arm_r <= 1'b0;
    end else if (status_rd_i && fault_r) begin
      fault_arm_r <= 1'b1;
    end
  end

  //////////////////////////////////////////////////
  // Outputs

  assign ctrl_o = ctrl_r;
  assign done_flag_o = done_r;
  assign mode_fault_o = fault_r;
  assign overrun_o = ovr_r;
  assign tx_empty_o = !full_r; // R20
  assign busy_o = (state_r == SPM_XFER);

  assign sck_o = cpol ^ tog_r; // R18
  assign sck_oe_o = en && master;
  assign mosi_o = sh_r[7]; // R01
  assign mosi_oe_o = en && master;
  assign miso_o = sh_r[7]; // R01
  assign miso_oe_o = en && !master && sel; // R03

endmodule : spm_port

`default_nettype wire

// file: rtl/spm_sync.sv
// Three-stage input synchroniser with agreement filter, per bit.
// Assumes inputs are asynchronous to sys_clk_i.
`timescale 1ns/1ps
`default_nettype none

module spm_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  generate
    if (WIDTH < 1) begin : g_bad
      $error("spm_sync: WIDTH must be at least 1");
    end
  endgenerate

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic out_r;
      always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
          s1_r <= RST_VAL[gi];
          s2_r <= RST_VAL[gi];
          s3_r <= RST_VAL[gi];
          out_r <= RST_VAL[gi];
        end else begin
          s1_r <= async_i[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
          // Change counts only once two stages agree
          if (s2_r == s3_r) begin
            out_r <= s3_r;
          end
        end
      end
      assign sync_o[gi] = out_r;
    end
  endgenerate

endmodule : spm_sync

`default_nettype wire
